// ### inc/adcls_pkg.sv
package adcls_pkg;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address on the bus is four times the index.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_MASK = 8'h03;
  localparam logic [7:0] IDX_SAMPLE_TIME = 8'h16;
  localparam logic [7:0] IDX_BYTE_THREE = 8'h17;
  localparam logic [7:0] IDX_COMMAND_INDEX = 8'h1C;
  localparam logic [7:0] IDX_COMMAND_BASE = 8'h1D;
  localparam logic [7:0] IDX_RESULT_INDEX = 8'h20;
  localparam logic [7:0] IDX_RESULT_BASE = 8'h21;
  localparam logic [7:0] IDX_OFFSET_ZERO = 8'h24;
  localparam logic [7:0] IDX_OFFSET_ONE = 8'h25;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SPECIAL_BIT = 1;
  localparam int CTRL_LIST_BIT = 2;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_PRESCALER_LSB = 8;
  localparam int STAT_ERROR_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int CMD_SAMPLE_LSB = 11;
  localparam int CMD_SAMPLE_BYTE_LSB = 8;

  // ---------------------------------------------------------------------------
  // Reset values and sample-time coding.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
  localparam logic [6:0] PRESCALER_RESET = 7'h00;
  localparam logic [21:0] COMMAND_BASE_RESET = 22'h00_0000;
  localparam logic [17:0] RESULT_BASE_RESET = 18'h0_0000;
  localparam logic [6:0] OFFSET_RESET = 7'h00;
  localparam logic [4:0] SAMPLE_CODE_MAX = 5'h14;
  localparam logic [5:0] SAMPLE_CYCLES_BASE = 6'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_CHECK,
    ST_SAMPLE,
    ST_STORE
  } adcls_state_t;

endpackage

// ### inc/adcls_timer_if.sv
`timescale 1ns/10ps
interface adcls_timer_if;
  logic enable;
  logic [6:0] prescaler;
  logic start;
  logic [5:0] sampleCycles;
  logic adcTick;
  logic sampleDone;

  modport timer (
    input enable,
    input prescaler,
    input start,
    input sampleCycles,
    output adcTick,
    output sampleDone
  );

  modport user (
    output enable,
    output prescaler,
    output start,
    output sampleCycles,
    input adcTick,
    input sampleDone
  );
endinterface

// ### hw/adcls_sample_timer.sv
`timescale 1ns/10ps
module adcls_sample_timer (
  input wire logic clk,
  input wire logic reset,
  adcls_timer_if.timer tmr
);

  logic [6:0] divCount;
  logic [5:0] remaining;
  logic tick;
  logic done;

  // ---------------------------------------------------------------------------
  // Prescaler divider.
  // ---------------------------------------------------------------------------

  // One ADC clock period lasts prescaler plus one module clocks.
  always_ff @(posedge clk) begin
    if (reset || !tmr.enable) begin
      divCount <= 7'h00;
      tick <= 1'b0;
    end else if (divCount == 7'h00) begin
      divCount <= tmr.prescaler;
      tick <= 1'b1;
    end else begin
      divCount <= divCount - 7'h01;
      tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Sample length counter.
  // ---------------------------------------------------------------------------

  // Counts ADC clock ticks down from the sample length and pulses at the end.
  always_ff @(posedge clk) begin
    if (reset || !tmr.enable) begin
      remaining <= 6'h00;
      done <= 1'b0;
    end else if (tmr.start) begin
      remaining <= tmr.sampleCycles;
      done <= 1'b0;
    end else if (tick && remaining != 6'h00) begin
      remaining <= remaining - 6'h01;
      done <= (remaining == 6'h01);
    end else begin
      done <= 1'b0;
    end
  end

  assign tmr.adcTick = tick;
  assign tmr.sampleDone = done;

endmodule

// ### hw/adcls_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
// Function
// - A fetched command with a reserved sample-time code sets the error flag and halts.
// - The sample-time byte reads at any time and takes writes only under special access.
// - Command bits 15 to 11 give the sample length in ADC clock cycles.
// - Codes 0 to 20 give code plus four cycles; higher codes are reserved.
// - The ADC clock period comes from the 7-bit prescaler setting.
// - The read-only command index counts 32-bit entries from the list start.
// - The command base bits 23 to 2 are writable when disabled or under special access.
// - Each fetch address uses the command base and the active list.
// - The read-only result index counts 16-bit entries from the list start.
// - The result base bits 19 to 2 locate results, stored at the end of each conversion.
// - The result base is writable only while the converter is disabled.
// - A command list holds at most 64 commands, so the index wraps after 63.
// - Addresses add a per-list offset in entry units to the base.
module adcls_top
  import adcls_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic memReq,
  output logic memWrite,
  output logic [23:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  input wire logic [15:0] conversionData,
  output logic irq
);

  adcls_timer_if tmr ();

  logic [31:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic doWrite;
  logic [7:0] wIdx;
  logic wMapped;
  logic [31:0] rValue;
  logic rMapped;
  logic enable;
  logic specialAccess;
  logic listSelect;
  logic run;
  logic [6:0] prescaler;
  logic [31:0] command;
  logic [21:0] commandBase;
  logic [17:0] resultBase;
  logic [6:0] offsetOne;
  logic [5:0] commandIndex;
  logic [5:0] resultIndex;
  logic [1:0] status;
  logic [1:0] mask;
  logic [6:0] listOffset;
  logic [23:0] fetchAddr;
  logic [23:0] storeAddr;
  logic codeReserved;
  logic errorEvent;
  logic doneEvent;
  adcls_state_t state;

  // Merges a write into an old value according to the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Bus write channels.
  // ---------------------------------------------------------------------------

  // Address and data are taken in either order and held until both are present.
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      awAddr <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      s_axi_awready <= !awHeld && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
    end
  end

  // Write data holding register.
  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      s_axi_wready <= !wHeld && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wIdx = awAddr[9:2];
  assign wMapped = (awAddr[31:10] == 22'h00_0000) && (wIdx == IDX_CONTROL
    || wIdx == IDX_STATUS || wIdx == IDX_MASK || wIdx == IDX_SAMPLE_TIME
    || wIdx == IDX_BYTE_THREE || wIdx == IDX_COMMAND_INDEX || wIdx == IDX_COMMAND_BASE
    || wIdx == IDX_RESULT_INDEX || wIdx == IDX_RESULT_BASE || wIdx == IDX_OFFSET_ZERO
    || wIdx == IDX_OFFSET_ONE);

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Control and pointer registers.
  // ---------------------------------------------------------------------------

  // Control bits; the run bit is dropped by hardware when a command is rejected.
  always_ff @(posedge clk) begin
    logic [31:0] v;
    v = merge({17'h0_0000, prescaler, 4'h0, run, listSelect, specialAccess, enable},
              wData, wStrb);
    if (reset) begin
      enable <= 1'b0;
      specialAccess <= 1'b0;
      listSelect <= 1'b0;
      run <= 1'b0;
      prescaler <= PRESCALER_RESET;
    end else begin
      if (doWrite && wMapped && wIdx == IDX_CONTROL) begin
        enable <= v[CTRL_ENABLE_BIT];
        specialAccess <= v[CTRL_SPECIAL_BIT];
        listSelect <= v[CTRL_LIST_BIT];
        run <= v[CTRL_RUN_BIT];
        prescaler <= v[CTRL_PRESCALER_LSB +: 7];
      end
      if (errorEvent) begin
        run <= 1'b0;
      end
    end
  end

  // Base pointers and the second list offset, each guarded by its own write condition.
  always_ff @(posedge clk) begin
    logic [31:0] vCmd;
    logic [31:0] vRes;
    logic [31:0] vOff;
    vCmd = merge({8'h00, commandBase, 2'h0}, wData, wStrb);
    vRes = merge({12'h000, resultBase, 2'h0}, wData, wStrb);
    vOff = merge({25'h000_0000, offsetOne}, wData, wStrb);
    if (reset) begin
      commandBase <= COMMAND_BASE_RESET;
      resultBase <= RESULT_BASE_RESET;
      offsetOne <= OFFSET_RESET;
    end else if (doWrite && wMapped) begin
      if (wIdx == IDX_COMMAND_BASE && (!enable || specialAccess)) begin
        commandBase <= vCmd[23:2];
      end
      if (wIdx == IDX_RESULT_BASE && !enable) begin
        resultBase <= vRes[19:2];
      end
      if (wIdx == IDX_OFFSET_ONE && (!enable || specialAccess)) begin
        offsetOne <= vOff[6:0];
      end
    end
  end

  // Active command: loaded from memory, or its sample byte patched under special access.
  always_ff @(posedge clk) begin
    logic [31:0] v;
    v = merge({24'h00_0000, command[CMD_SAMPLE_BYTE_LSB +: 8]}, wData, wStrb);
    if (reset) begin
      command <= COMMAND_RESET;
    end else if (state == ST_FETCH && memAck) begin
      command <= memRdata;
    end else if (doWrite && wMapped && wIdx == IDX_SAMPLE_TIME && specialAccess) begin
      command[CMD_SAMPLE_BYTE_LSB +: 8] <= v[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Status, mask and interrupt.
  // ---------------------------------------------------------------------------

  // Sticky flags clear on a written one; a new event in the same cycle wins.
  always_ff @(posedge clk) begin
    logic [1:0] clr;
    clr = (doWrite && wMapped && wIdx == IDX_STATUS && wStrb[0]) ? wData[1:0] : 2'h0;
    if (reset) begin
      status <= 2'h0;
      mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      status[STAT_ERROR_BIT] <= errorEvent || (status[STAT_ERROR_BIT] && !clr[0]);
      status[STAT_DONE_BIT] <= doneEvent || (status[STAT_DONE_BIT] && !clr[1]);
      if (doWrite && wMapped && wIdx == IDX_MASK && wStrb[0]) begin
        mask <= wData[1:0];
      end
      irq <= |(status & mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Address generation and sequencer.
  // ---------------------------------------------------------------------------

  assign listOffset = listSelect ? offsetOne : OFFSET_RESET;
  assign fetchAddr = {commandBase, 2'h0}
    + {14'h0000, 8'(listOffset + 7'(commandIndex)), 2'h0};
  assign storeAddr = {4'h0, resultBase, 2'h0}
    + {15'h0000, 8'(listOffset + 7'(resultIndex)), 1'b0};
  assign codeReserved = command[CMD_SAMPLE_LSB +: 5] > SAMPLE_CODE_MAX;
  assign errorEvent = (state == ST_CHECK) && codeReserved;
  assign doneEvent = (state == ST_STORE) && memAck;

  assign tmr.enable = enable;
  assign tmr.prescaler = prescaler;
  assign tmr.start = (state == ST_CHECK) && !codeReserved;
  assign tmr.sampleCycles = 6'(command[CMD_SAMPLE_LSB +: 5]) + SAMPLE_CYCLES_BASE;

  // Fetch, check, sample and store loop over the active list.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 24'h00_0000;
      memWdata <= 16'h0000;
      commandIndex <= 6'h00;
      resultIndex <= 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!enable) begin
            commandIndex <= 6'h00;
            resultIndex <= 6'h00;
          end else if (run) begin
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memAddr <= fetchAddr;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (memAck) begin
            memReq <= 1'b0;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state <= codeReserved ? ST_IDLE : ST_SAMPLE;
        end
        ST_SAMPLE: begin
          if (!enable) begin
            state <= ST_IDLE;
          end else if (tmr.sampleDone) begin
            memReq <= 1'b1;
            memWrite <= 1'b1;
            memAddr <= storeAddr;
            memWdata <= conversionData;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (memAck) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            commandIndex <= commandIndex + 6'h01;
            resultIndex <= resultIndex + 6'h01;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  adcls_sample_timer u_timer (
    .clk(clk),
    .reset(reset),
    .tmr(tmr)
  );

  // ---------------------------------------------------------------------------
  // Bus read channel.
  // ---------------------------------------------------------------------------

  // Read multiplexer; index registers ignore writes and report the sequencer position.
  always_comb begin
    rValue = 32'h0000_0000;
    rMapped = (s_axi_araddr[31:10] == 22'h00_0000);
    case (s_axi_araddr[9:2])
      IDX_CONTROL: rValue = {17'h0_0000, prescaler, 4'h0, run, listSelect, specialAccess,
                             enable};
      IDX_STATUS: rValue = {30'h0000_0000, status};
      IDX_MASK: rValue = {30'h0000_0000, mask};
      IDX_SAMPLE_TIME: rValue = {24'h00_0000, command[CMD_SAMPLE_BYTE_LSB +: 8]};
      IDX_BYTE_THREE: rValue = 32'h0000_0000;
      IDX_COMMAND_INDEX: rValue = {26'h000_0000, commandIndex};
      IDX_COMMAND_BASE: rValue = {8'h00, commandBase, 2'h0};
      IDX_RESULT_INDEX: rValue = {26'h000_0000, resultIndex};
      IDX_RESULT_BASE: rValue = {12'h000, resultBase, 2'h0};
      IDX_OFFSET_ZERO: rValue = 32'h0000_0000;
      IDX_OFFSET_ONE: rValue = {25'h000_0000, offsetOne};
      default: rMapped = 1'b0;
    endcase
  end

  // One read at a time; the answer comes one cycle after the address is taken.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rValue;
      s_axi_rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### verification/adcls_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Port checker for the list sequencer top.
// ----------------------------------------------------------------------
module adcls_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic memAck,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Memory port: requests hold still until taken, then drop.
  req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memWrite))
    else $error("memory request changed before ack");
  req_drop_a: assert property (memReq && memAck |=> !memReq)
    else $error("memory request stayed after ack");
  min_sample_a: assert property (memReq && !memWrite && memAck |=> !memReq [*4])
    else $error("store came before the shortest sample time");
  fetch_align_a: assert property (memReq && !memWrite |-> memAddr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  store_align_a: assert property (memReq && memWrite |-> memAddr[0] == 1'b0)
    else $error("store address not halfword aligned");

  // Register bus: answers stand until taken.
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> !memReq && !irq && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule

// ### verification/adcls_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// System memory behind the command fetch and result store port.
// ----------------------------------------------------------------------
module adcls_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] cmdMem [0:63];
  logic [23:0] fetchAddr[$];
  logic [23:0] storeAddr[$];
  logic [15:0] storeData[$];
  int gap[$];
  int cycle = 0;
  int waitCnt;
  int ackCycle;
  logic prevReq;

  // Answers after zero or three wait cycles and logs every access.
  always @(posedge clk) begin
    cycle <= cycle + 1;
    prevReq <= memReq;
    memAck <= 1'b0;
    memRdata <= ~memRdata; // Released data flips every cycle, so it holds the last word every other cycle.
    if (memReq && !prevReq && memWrite) gap.push_back(cycle - ackCycle);
    if (reset) begin
      waitCnt <= 0;
      memRdata <= 32'h0000_0000;
    end else if (memReq && !memAck) begin
      if (waitCnt == (slow ? 3 : 0)) begin
        memAck <= 1'b1;
        waitCnt <= 0;
        if (memWrite) begin
          storeAddr.push_back(memAddr);
          storeData.push_back(memWdata);
        end else begin
          fetchAddr.push_back(memAddr);
          memRdata <= cmdMem[memAddr[7:2]];
          ackCycle <= cycle;
        end
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
bind adcls_top adcls_chk i_adcls_chk (.clk, .reset, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .memReq, .memWrite, .memAddr, .memAck, .irq);

module tb;
  import adcls_pkg::*;
  logic clk, reset, slow, memReq, memWrite, memAck, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, memRdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [23:0] memAddr;
  logic [15:0] memWdata, conversionData;
  int miscompares, n_tests, f0, s0;

  adcls_top i_adcls_top (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .memReq, .memWrite, .memAddr, .memWdata, .memAck,
    .memRdata, .conversionData, .irq);
  adcls_mem_model i_mem (.clk, .reset, .slow, .memReq, .memWrite, .memAddr, .memWdata,
    .memAck, .memRdata);

  // ----------------------------------------------------------------------
  // Checking and bus tasks.
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 20000) begin
      chk(32'h0000_0000, 32'h0000_0001, "wait ran out");
      tally_and_finish();
    end
  endtask

  // Offers address and data together and releases each once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic ga, gw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      if (s_axi_bvalid) break;
      if (s_axi_awready && !ga) begin
        ga = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !gw) begin
        gw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    hang(n);
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask

  // Reads one word and compares data and response.
  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    hang(n);
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    if (er == RESP_OKAY) chk(s_axi_rdata, exp, "read data");
  endtask

  // Waits until the memory has seen enough fetches and stores.
  task automatic waitQ(input int fetches, input int stores);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      if (i_mem.fetchAddr.size() >= fetches && i_mem.storeAddr.size() >= stores) break;
    end
    hang(n);
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Clock and test sequence.
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    {reset, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h20;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    conversionData = 16'h5A3C;
    miscompares = 0;
    n_tests = 0;
    for (int i = 0; i < 64; i++) i_mem.cmdMem[i] = 32'h0000_0000;
    i_mem.cmdMem[1] = 32'h0000_A000;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(32'h70, 32'h0);
    wr(32'h70, 32'h3F);
    rd(32'h70, 32'h0);
    wr(32'h80, 32'h3F);
    rd(32'h80, 32'h0);
    wr(32'h3FC, 32'h1, RESP_SLVERR);
    rd(32'h3FC, 32'h0, RESP_SLVERR);
    wr(32'h74, 32'h00FF_FFFF);
    rd(32'h74, 32'h00FF_FFFC);
    wr(32'h84, 32'h00FF_FFFF);
    rd(32'h84, 32'h000F_FFFC);
    wr(32'h74, 32'h100);
    wr(32'h84, 32'h2000);
    wr(32'h0C, 32'h1);
    $display("test registers done");
    wr(32'h04, 32'h0209);
    waitQ(0, 64);
    i_mem.cmdMem[1] = 32'h0000_A800;
    waitQ(66, 65);
    chk({8'h0, i_mem.storeAddr[1]}, 32'h2002, "store address");
    chk(32'(i_mem.gap[1] - i_mem.gap[0] inside {[58:62]}), 32'h1, "sample length");
    chk({16'h0, i_mem.storeData[1]}, 32'h5A3C, "store data");
    chk({8'h0, i_mem.storeAddr[64]}, 32'h2000, "wrapped store");
    chk({8'h0, i_mem.fetchAddr[64]}, 32'h100, "wrapped fetch");
    chk({8'h0, i_mem.fetchAddr[65]}, 32'h104, "fetch address");
    chk(32'(i_mem.storeAddr.size()), 32'd65, "store count");
    rd(32'h08, 32'h3);
    rd(32'h04, 32'h0201);
    rd(32'h70, 32'h1);
    rd(32'h80, 32'h1);
    rd(32'h58, 32'hA8);
    chk({31'h0, irq}, 32'h1, "irq on error");
    wr(32'h08, 32'h1);
    rd(32'h08, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(32'h0C, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq on done");
    wr(32'h08, 32'h2);
    rd(32'h08, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test conversion run done");
    wr(32'h58, 32'h20);
    rd(32'h58, 32'hA8);
    wr(32'h74, 32'h200);
    rd(32'h74, 32'h100);
    wr(32'h04, 32'h0203);
    wr(32'h58, 32'h20);
    rd(32'h58, 32'h20);
    wr(32'h74, 32'h200);
    rd(32'h74, 32'h200);
    wr(32'h84, 32'h4000);
    rd(32'h84, 32'h2000);
    wr(32'h74, 32'h100);
    wr(32'h04, 32'h0);
    rd(32'h70, 32'h0);
    wr(32'h94, 32'h5);
    $display("test guarded writes done");
    i_mem.cmdMem[6] = 32'h0000_F800;
    f0 = i_mem.fetchAddr.size();
    s0 = i_mem.storeAddr.size();
    slow <= 1'b1;
    wr(32'h04, 32'h020D);
    waitQ(f0 + 2, s0 + 1);
    chk({8'h0, i_mem.fetchAddr[f0]}, 32'h114, "list one fetch");
    chk({8'h0, i_mem.fetchAddr[f0 + 1]}, 32'h118, "list one next");
    chk({8'h0, i_mem.storeAddr[s0]}, 32'h200A, "list one store");
    rd(32'h08, 32'h3);
    $display("test list one done");
    tally_and_finish();
  end
endmodule
